/* include/mtt_pkg.sv */
// Function
// - count is readable only; writes ignored; reset makes it zero.
// - limit is read/write, resets to zero; zero means full 8-bit range.
// - any limit write zeroes count and clears wrap flag.
// - reset leaves counter halted, zero count/limit, bus clock, divide one.
// - modes are halted, free-running (limit zero) and modulo (limit nonzero).
// - sources are bus clock, fixed clock, tick pin rising or falling.
// - source change while running keeps the count.
// - prescaler divides by 1, 2, 4, 8, 16, 32, 64, 128 or 256.
// - divide change while running keeps the count.
// - running count steps per tick up to limit, then wraps to zero.
// - wrap flag sets on the tick from limit to zero.
// - flag clears by status read while set, then writing zero; new wrap wins.
// - count-clear write or limit write also clears the flag.
// - interrupt request is flag and enable both high.
// - limit takes any value 1 to 255 for modulo counting.
// - source field bits 5:4: 00 bus, 01 fixed, 10 fall, 11 rise.
// - divide field 0..8 gives 2^n; above 8 gives 256.
// - halt freezes count; clearing it resumes; reset sets halt.
// - count-clear bit zeroes count and flag; reads as zero.
package mtt_pkg;
  // -----------------------------------------------------------
  // register map (byte addresses)
  // -----------------------------------------------------------
  localparam logic [3:0] ADR_CTRL  = 4'h0;
  localparam logic [3:0] ADR_CLK   = 4'h4;
  localparam logic [3:0] ADR_COUNT = 4'h8;
  localparam logic [3:0] ADR_LIMIT = 4'hc;
  // -----------------------------------------------------------
  // field positions
  // -----------------------------------------------------------
  localparam int BIT_FLAG  = 7;
  localparam int BIT_IEN   = 6;
  localparam int BIT_CLR   = 5;
  localparam int BIT_HALT  = 4;
  localparam int SRC_LSB   = 4;
  localparam int DIV_LSB   = 0;
  // -----------------------------------------------------------
  // reset values and encodings
  // -----------------------------------------------------------
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_LIMIT = 8'h00;
  localparam logic [1:0] RST_SRC   = 2'h0;
  localparam logic [3:0] RST_DIV   = 4'h0;
  localparam logic [3:0] DIV_MAX   = 4'h8;
  localparam logic [7:0] CNT_TOP   = 8'hff;
  localparam logic [1:0] SRC_BUS   = 2'h0;
  localparam logic [1:0] SRC_FIX   = 2'h1;
  localparam logic [1:0] SRC_FALL  = 2'h2;
  localparam logic [1:0] SRC_RISE  = 2'h3;
endpackage

/* hdl/mtt_timer.sv */
module mtt_timer
  import mtt_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // outside inputs
  input  wire logic        fixed_frequency_clock,
  input  wire logic        external_tick_pin,
  // interrupt request
  output logic             wrap_irq
);
  import mtt_pkg::*;

  // -----------------------------------------------------------
  // helpers
  // -----------------------------------------------------------
  // mask of prescaler bits that must be all ones for a tick
  function automatic logic [7:0] div_mask(input logic [3:0] sel);
    logic [3:0] n;
    n = (sel > DIV_MAX) ? DIV_MAX : sel;
    div_mask = 8'((9'h1 << n) - 9'h1);
  endfunction

  // -----------------------------------------------------------
  // outside inputs: three flops, edge once stages two and three agree
  // -----------------------------------------------------------
  logic [1:0] in_raw;
  logic [1:0] s1, s2, s3, filt;
  logic [1:0] next_filt;
  logic [1:0] rise_ev, fall_ev;
  assign in_raw = {external_tick_pin, fixed_frequency_clock};

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_sync
      always_comb
      begin
        next_filt[g] = filt[g];
        rise_ev[g]   = 1'b0;
        fall_ev[g]   = 1'b0;
        if (s2[g] == s3[g] && s2[g] != filt[g])
        begin
          next_filt[g] = s2[g];
          rise_ev[g]   = s2[g];
          fall_ev[g]   = ~s2[g];
        end
      end
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          s1[g]   <= 1'b0;
          s2[g]   <= 1'b0;
          s3[g]   <= 1'b0;
          filt[g] <= 1'b0;
        end
        else
        begin
          s1[g]   <= in_raw[g];
          s2[g]   <= s1[g];
          s3[g]   <= s2[g];
          filt[g] <= next_filt[g];
        end
      end
    end
  endgenerate

  // -----------------------------------------------------------
  // registers and bus slave
  // -----------------------------------------------------------
  logic [7:0] count, limit;
  logic [1:0] src;
  logic [3:0] dsel;
  logic       halt, ien, flag, armed;
  logic [7:0] pre;
  logic [7:0] next_count, next_limit, next_pre;
  logic [1:0] next_src;
  logic [3:0] next_dsel;
  logic       next_halt, next_ien, next_flag, next_armed;
  logic [31:0] next_dat;
  logic       next_ack;
  logic       acc, wr, rd, lane0;
  logic       src_ev, tick, wrap, clr_req, lim_wr;

  // a request completes on the edge where ack is high
  assign acc   = wb_cyc_i & wb_stb_i & wb_ack_o;
  assign lane0 = wb_sel_i[0];
  assign wr    = acc & wb_we_i & lane0;
  assign rd    = acc & ~wb_we_i;
  assign lim_wr  = wr && wb_adr_i == ADR_LIMIT;
  assign clr_req = wr && wb_adr_i == ADR_CTRL && wb_dat_i[BIT_CLR];

  // source pick; unknown codes cannot occur in two bits
  always_comb
  begin
    unique case (src)
      SRC_BUS:  src_ev = 1'b1;
      SRC_FIX:  src_ev = rise_ev[0];
      SRC_FALL: src_ev = fall_ev[1];
      SRC_RISE: src_ev = rise_ev[1];
    endcase
  end

  // prescaler runs only while counting so halt freezes it too
  assign tick = ~halt & src_ev & ((pre & div_mask(dsel)) == div_mask(dsel));
  // limit zero wraps at the top of the range
  assign wrap = tick &&
                count == ((limit == RST_LIMIT) ? CNT_TOP : limit);

  always_comb
  begin
    next_pre   = pre;
    next_count = count;
    next_limit = limit;
    next_src   = src;
    next_dsel  = dsel;
    next_halt  = halt;
    next_ien   = ien;
    next_flag  = flag;
    next_armed = armed;
    if (~halt && src_ev)
      next_pre = pre + 8'h01;
    // selection changes never touch count
    if (wr && wb_adr_i == ADR_CLK)
    begin
      next_src  = wb_dat_i[SRC_LSB +: 2];
      next_dsel = wb_dat_i[DIV_LSB +: 4];
    end
    if (wr && wb_adr_i == ADR_CTRL)
    begin
      next_halt = wb_dat_i[BIT_HALT];
      next_ien  = wb_dat_i[BIT_IEN];
      if (armed && ~wb_dat_i[BIT_FLAG])
        next_flag = 1'b0;
      next_armed = 1'b0;
    end
    if (rd && wb_adr_i == ADR_CTRL && flag)
      next_armed = 1'b1;
    if (lim_wr)
      next_limit = wb_dat_i[7:0];
    if (tick)
      next_count = wrap ? RST_COUNT : count + 8'h01;
    if (lim_wr || clr_req)
    begin
      next_count = RST_COUNT;
      next_flag  = 1'b0;
      next_armed = 1'b0;
    end
    // a wrap beats the two-step clear but not a count-clear or limit write, and voids an earlier read
    if (wrap && !(lim_wr || clr_req))
    begin
      next_flag  = 1'b1;
      next_armed = 1'b0;
    end
  end

  // read data; unmapped words read zero
  always_comb
  begin
    next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    next_dat = 32'h0;
    unique case (wb_adr_i)
      ADR_CTRL:
        next_dat[7:0] = {flag, ien, 1'b0, halt, 4'h0};
      ADR_CLK:
        next_dat[7:0] = {2'h0, src, dsel};
      ADR_COUNT:
        next_dat[7:0] = count;
      ADR_LIMIT:
        next_dat[7:0] = limit;
      default:
        next_dat = 32'h0;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pre      <= 8'h00;
      count    <= RST_COUNT;
      limit    <= RST_LIMIT;
      src      <= RST_SRC;
      dsel     <= RST_DIV;
      halt     <= 1'b1;
      ien      <= 1'b0;
      flag     <= 1'b0;
      armed    <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      wrap_irq <= 1'b0;
    end
    else
    begin
      pre      <= next_pre;
      count    <= next_count;
      limit    <= next_limit;
      src      <= next_src;
      dsel     <= next_dsel;
      halt     <= next_halt;
      ien      <= next_ien;
      flag     <= next_flag;
      armed    <= next_armed;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
      wrap_irq <= next_flag & next_ien;
    end
  end

  // -----------------------------------------------------------
  // checks
  // -----------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_status_read;
    rd && wb_adr_i == ADR_CTRL && flag;
  endsequence
  sequence s_zero_write;
    wr && wb_adr_i == ADR_CTRL && !wb_dat_i[BIT_FLAG] && !wrap
      && !wb_dat_i[BIT_CLR];
  endsequence

  a_count_ro: assert property (
    wr && wb_adr_i == ADR_COUNT && !tick |=> $stable(count))
    else $error("count changed on a count write");
  a_limit_zero: assert property (
    lim_wr |=> count == RST_COUNT && !flag)
    else $error("limit write left count or flag");
  a_halt_hold: assert property (
    halt && !lim_wr && !clr_req |=> $stable(count))
    else $error("count moved while halted");
  a_wrap_zero: assert property (
    wrap && !lim_wr && !clr_req |=> count == RST_COUNT && flag)
    else $error("wrap did not zero count and set flag");
  a_step_one: assert property (
    tick && !wrap && !lim_wr && !clr_req |=> count == $past(count) + 8'h01)
    else $error("count did not step by one");
  a_flag_clear: assert property (
    armed ##0 s_zero_write |=> !flag)
    else $error("two step clear failed");
  a_wrap_wins: assert property (
    wrap && !lim_wr && !clr_req |=> flag && !armed)
    else $error("wrap lost against clear");
  a_clr_bit: assert property (
    clr_req |=> count == RST_COUNT && !flag)
    else $error("count clear failed");
  a_irq_gate: assert property (
    s_status_read |=> armed || flag && $past(wrap) ##0
      wrap_irq == (flag && ien))
    else $error("irq does not follow flag and enable");
  a_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
endmodule

/* verification/modulo_tick_timer_test.sv */
`define CHK(s, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %s exp %h got %h", s, e, g); end end
module modulo_tick_timer_test;
  timeunit 1ns;
  timeprecision 1ns;
  import mtt_pkg::*;
  // ---------------------------------------------
  // signals
  // ---------------------------------------------
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        req = 1'b0;
  logic        we  = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        fix = 1'b0;
  logic        pin = 1'b0;
  logic        irq;
  logic [7:0]  q;
  int          error_cnt = 0;
  int          cmp_count = 0;
  typedef struct {
    logic [3:0] a;
    logic [7:0] w;
    logic [7:0] e;
  } mtt_row_t;
  mtt_row_t rows [9] = '{'{ADR_LIMIT, 8'haa, 8'haa},
    '{ADR_LIMIT, 8'hff, 8'hff}, '{ADR_COUNT, 8'h55, 8'h00},
    '{ADR_CLK, 8'hff, 8'h3f}, '{ADR_CTRL, 8'h5f, 8'h50},
    '{ADR_CTRL, 8'h10, 8'h10}, '{4'h2, 8'hff, 8'h00},
    '{ADR_CLK, 8'h00, 8'h00}, '{ADR_LIMIT, 8'h00, 8'h00}};
  always #50 clk = ~clk;
  mtt_timer mtt_timer_inst (
    .clk                   (clk),
    .rst                   (rst),
    .wb_cyc_i              (req),
    .wb_stb_i              (req),
    .wb_we_i               (we),
    .wb_adr_i              (adr),
    .wb_sel_i              (4'hf),
    .wb_dat_i              (dat),
    .wb_dat_o              (rdat),
    .wb_ack_o              (ack),
    .fixed_frequency_clock (fix),
    .external_tick_pin     (pin),
    .wrap_irq              (irq)
  );
  // ---------------------------------------------
  // bus and helper tasks
  // ---------------------------------------------
  task automatic tally_and_finish;
    $display("errors %0d of %0d compares", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk);
    req <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    r = rdat[7:0];
    req <= 1'b0;
    if (n >= 20)
    begin
      error_cnt++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] r;
    wb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e,
                    input string s);
    logic [7:0] r;
    wb(1'b0, a, 8'h00, r);
    `CHK(s, e, r)
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 50)
    begin
      error_cnt++;
      tally_and_finish();
    end
  endtask
  task automatic pulse(input logic f);
    repeat (5)
    begin
      repeat (4) @(posedge clk);
      if (f) fix <= 1'b1; else pin <= 1'b1;
      repeat (4) @(posedge clk);
      if (f) fix <= 1'b0; else pin <= 1'b0;
    end
    repeat (6) @(posedge clk);
  endtask
  task automatic reset_chk;
    rd(ADR_CTRL, 8'h10, "ctrl");
    rd(ADR_CLK, 8'h00, "cfg");
    rd(ADR_COUNT, 8'h00, "count");
    rd(ADR_LIMIT, 8'h00, "limit");
  endtask
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial
  begin
    int e;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    reset_chk(); // reset state
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].e, "row");
    end
    // divide ratios, prescaler phase left free so allow slack
    for (int k = 0; k < 10; k++)
    begin
      wr(ADR_CTRL, 8'h30);
      wr(ADR_CLK, (k == 9) ? 8'h0f : 8'(k));
      wr(ADR_CTRL, 8'h00);
      repeat (240) @(posedge clk);
      wr(ADR_CTRL, 8'h10);
      e = 240 >> ((k > 8) ? 8 : k);
      wb(1'b0, ADR_COUNT, 8'h00, q);
      `CHK("div", 1'b1, (int'(q) + 1 >= e && int'(q) <= e + 4))
    end
    // switch source while running, count carries on
    wr(ADR_CTRL, 8'h30);
    wr(ADR_CLK, 8'h30);
    wr(ADR_CTRL, 8'h00);
    for (int s = 1; s < 4; s++)
    begin
      if (s > 1) wr(ADR_CLK, {2'(4 - s), 4'h0});
      pulse(s == 3);
      rd(ADR_COUNT, 8'(5 * s), "src");
    end
    wr(ADR_LIMIT, 8'h03);
    wr(ADR_CLK, 8'h00);
    wr(ADR_CTRL, 8'h40);
    wait_irq();
    wr(ADR_CTRL, 8'h50);
    wb(1'b0, ADR_COUNT, 8'h00, q);
    `CHK("mod", 1'b1, q <= 8'h03)
    rd(ADR_CTRL, 8'hd0, "flag"); // no armed read yet
    `CHK("irq", 1'b1, irq)
    wr(ADR_CTRL, 8'h50);
    rd(ADR_CTRL, 8'h50, "clear");
    `CHK("irq", 1'b0, irq)
    wr(ADR_CTRL, 8'h40); // flag clear before halt is released
    wait_irq();
    rd(ADR_CTRL, 8'hc0, "flag");
    repeat (8) @(posedge clk);
    wr(ADR_CTRL, 8'h50);
    rd(ADR_CTRL, 8'hd0, "again"); // later wrap keeps it
    wr(ADR_LIMIT, 8'h03);
    rd(ADR_CTRL, 8'h50, "lim");
    rd(ADR_COUNT, 8'h00, "lim");
    wr(ADR_CTRL, 8'h40);
    wait_irq();
    wr(ADR_CTRL, 8'h30);
    rd(ADR_CTRL, 8'h10, "clr");
    rd(ADR_COUNT, 8'h00, "clr");
    `CHK("irq", 1'b0, irq)
    // second reset while running
    wr(ADR_CTRL, 8'h00);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    reset_chk();
    tally_and_finish();
  end
endmodule
